// ==== vm_setup_pkg.sv ====
// package: encodings, field layouts, reset values and timing counts for the voltmeter setup state
package vm_setup_pkg;

  localparam int SYS_CLK_HZ = 25_000_000;

  // register offsets
  localparam logic [3:0] ADDR_CMD      = 4'h0;
  localparam logic [3:0] ADDR_QUANTITY_SELECT     = 4'h1;
  localparam logic [3:0] ADDR_TRIG     = 4'h2;
  localparam logic [3:0] ADDR_SCAN     = 4'h3;
  localparam logic [3:0] ADDR_RANGE    = 4'h4;
  localparam logic [3:0] ADDR_NRDG     = 4'h5;
  localparam logic [3:0] ADDR_DEST     = 4'h6;
  localparam logic [3:0] ADDR_TDELAY   = 4'h7;
  localparam logic [3:0] ADDR_SPERIOD  = 4'h8;
  localparam logic [3:0] ADDR_PROFILE  = 4'h9;
  localparam logic [3:0] ADDR_XFER     = 4'hA;
  localparam logic [3:0] ADDR_STATUS   = 4'hB;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'hC;
  localparam logic [3:0] ADDR_INTR_EN  = 4'hD;

  // command codes written to ADDR_CMD
  localparam logic [1:0] CMD_SETUP   = 2'h1;
  localparam logic [1:0] CMD_ACQUIRE = 2'h2;
  localparam logic [1:0] CMD_RESET   = 2'h3;

  // command field positions: [1:0] code, [4:2] quantity_select
  localparam int CMD_CODE_LSB = 0;
  localparam int CMD_QUANTITY_SELECT_LSB = 2;

  // scan sources
  localparam logic [1:0] SRC_SCAN = 2'h0;
  localparam logic [1:0] SRC_HOLD = 2'h1;
  localparam logic [1:0] SRC_INT  = 2'h2;
  localparam logic [1:0] SRC_SGL  = 2'h3;

  // quantity_select codes
  localparam logic [2:0] QUANTITY_SELECT_DCV = 3'h0;

  localparam logic [1:0] RANGE_AUTO   = 2'h0;
  localparam logic       TERM_EXT     = 1'b0;
  localparam logic       TERM_BUS     = 1'b1;
  localparam logic [1:0] DEST_HOST    = 2'h0;
  localparam logic       STORE_ANY    = 1'b0;
  localparam logic       AUTORANGE_AFTER = 1'b0;
  localparam logic [1:0] NULL_ONCE    = 2'h0;

  // times: delay in ns, period in ns; held as count of 40 ns cycles
  localparam int TDELAY_PRESET_NS = 1_000_000;
  localparam int SPERIOD_NS       = 10_000;
  localparam int CLK_NS           = 1_000_000_000 / SYS_CLK_HZ;
  localparam logic [31:0] TDELAY_PRESET_CYC = 32'(TDELAY_PRESET_NS / CLK_NS);
  localparam logic [31:0] SPERIOD_CYC       = 32'(SPERIOD_NS / CLK_NS);
  localparam logic [31:0] TDELAY_RESET_CYC  = 32'h0000_0000;

  localparam logic [15:0] NRDG_RESET = 16'h0001;
  localparam logic [15:0] NRDG_MIN   = 16'h0001;

  // status bits
  localparam int ST_SETUP_DONE = 0;
  localparam int ST_SCAN_STEP  = 1;
  localparam int ST_SCAN_END   = 2;
  localparam int ST_REJECT     = 3;
  localparam int ST_W          = 4;

  // preset step numbering, twelve steps
  localparam logic [3:0] PRESET_LAST = 4'hB;

  typedef struct packed {
    logic [1:0] scan_begin_source;
    logic [1:0] scan_step_source;
    logic [1:0] trig_source;
    logic [2:0] quantity_select;
    logic [1:0] range_sel;
    logic       terminal;
    logic [15:0] samples_per_trigger;
    logic [1:0] destination;
    logic       result_storage_policy;
    logic       autorange_policy;
    logic [31:0] trig_delay;
    logic [31:0] sample_period;
    logic [1:0] offset_nulling_mode;
  } vm_cfg_t;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_PRESET = 4'b0010,
    ST_SCAN   = 4'b0100,
    ST_WAIT   = 4'b1000
  } seq_state_t;

  localparam vm_cfg_t CFG_RESET = '{
    scan_begin_source: SRC_SCAN, scan_step_source: SRC_SCAN, trig_source: SRC_HOLD,
    quantity_select: QUANTITY_SELECT_DCV, range_sel: RANGE_AUTO, terminal: TERM_EXT,
    samples_per_trigger: NRDG_RESET, destination: DEST_HOST,
    result_storage_policy: STORE_ANY, autorange_policy: AUTORANGE_AFTER,
    trig_delay: TDELAY_RESET_CYC, sample_period: SPERIOD_CYC, offset_nulling_mode: NULL_ONCE};

endpackage

// ==== voltmeter_setup_preset_state.sv ====
// voltmeter setup, preset sequencing and acquire gating in system mode
`timescale 1ns/1ps
module voltmeter_setup_preset_state
  import vm_setup_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset_n,
  input  wire logic [3:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic        i_reading_stored,
  input  wire logic        i_reading_taken,
  output logic [31:0]      o_rdata,
  output vm_cfg_t          o_cfg,
  output logic             o_scanning,
  output logic             o_any_result_ready,
  output logic             o_scan_step,
  output logic [15:0]      o_xfer_count,
  output logic             o_xfer_go,
  output logic             o_irq
);

  // register map, one 32-bit word per index, narrow fields in the low bits
  //   0x0  command word, write only, reads as zero
  //        [1:0] command code: 1 setup, 2 acquire or stop, 3 reset
  //        [4:2] quantity_select handed to the preset
  //   0x1  quantity_select, [2:0]
  //   0x2  trigger source, [1:0]
  //   0x3  scan sources, [1:0] scan_begin_source, [3:2] scan_step_source
  //   0x4  front end, [1:0] range, [2] terminal, [3] autorange, [5:4] nulling
  //   0x5  samples_per_trigger, [15:0], zero is refused
  //   0x6  destination [1:0], result_storage_policy [2]
  //   0x7  trigger delay in clock cycles
  //   0x8  sample period in clock cycles
  //   0x9  operating_profile, [0]
  //   0xA  transfer request, [15:0] count, zero means samples_per_trigger
  //        reads back {readings held, last transfer count}
  //   0xB  status, write one to clear; reads back the sequencer state in [7:4]
  //   0xC  interrupt mask, same layout as status
  //   0xD  interrupt enable, [0], off after reset
  //   other indices: writes ignored, reads zero
  //
  // status bits
  //   [0] preset finished
  //   [1] scan stepped to the next channel
  //   [2] scan ended by a second acquire
  //   [3] request refused
  //
  // timing of the register port
  //   write: strobe, index and data in one cycle, effect visible the cycle after
  //   read: strobe and index in one cycle, data on o_rdata in the next cycle only
  //   strobes may follow back to back; the port never stalls
  //   a read of the command word or of an unused index returns zero
  //
  // preset walk after a setup write at cycle 0
  //   c1 scan begin source    c2 scan step source     c3 trigger hold
  //   c4 quantity select      c5 range auto           c6 bus terminal
  //   c7 one sample           c8 host destination     c9 any-result policy
  //   c10 autorange after     c11 delay and period    c12 nulling once, done flag
  //   a second setup during the walk is ignored, so the walk never restarts midway
  //   low-level writes during the walk may be overwritten by a later step
  //
  // acquire and scan
  //   an acquire from idle starts the scan; a second acquire stops it
  //   an acquire is refused while interrupts are enabled, while the profile is on
  //   or while the preset is still running; the refusal sets status bit 3
  //   the scan waits for samples_per_trigger readings, then for the buffer to drain,
  //   and only then pulses o_scan_step for one cycle
  //   a store in the same cycle as the drain holds the step back until the buffer drains again
  //
  // hazards
  //   stored and taken in one cycle leave the reading count as it is
  //   a take with an empty count is ignored, so the count never wraps below zero
  //   more than 65535 held readings wrap the count
  //   a reset command loads the reset state at the next edge; a status event from the same cycle stays set
  //   a status clear in the same cycle as its event keeps the bit set
  //   an acquire in the wait state ends the scan at once, readings stay held
  //
  // field encodings
  //   scan sources: 0 immediate, 1 hold, 2 internal, 3 single
  //   trigger source: 1 hold, other codes as for the scan sources
  //   quantity_select: 0 dc volts, other codes for further functions
  //   range: 0 auto
  //   terminal: 0 external terminals, 1 backplane bus
  //   destination: 0 host frame
  //   result_storage_policy: 0 ready once a single reading is stored
  //   autorange_policy: 0 autorange after each measurement
  //   offset_nulling_mode: 0 null once
  //   times: 40 ns per count, so 1 ms is 25000 and 10 us is 250
  //
  // reset values
  //   scan sources immediate, trigger hold, dc volts, range auto, external terminals
  //   one sample per trigger, host destination, any-result policy, autorange after
  //   zero trigger delay, 250-cycle sample period, null once
  //   operating profile off, interrupts off, status and mask clear
  //
  // outputs
  //   o_cfg               live configuration, one field per setting
  //   o_scanning          high in the scan and wait states
  //   o_any_result_ready  high while at least one reading is held
  //   o_scan_step         one-cycle pulse when the scan may move on
  //   o_xfer_go           one-cycle pulse the cycle after a transfer request
  //   o_xfer_count        count of the last transfer request
  //   o_irq               level, enabled and unmasked status bits
  //   o_rdata             read data for one cycle, zero otherwise
  //
  // clock and reset
  //   one clock, i_sys_clk at 25 MHz; every field updates on its rising edge
  //   i_reset_n clears the state at once, without waiting for the clock
  //   all inputs come from logic on the same clock, so none is synchronised here
  //   the first request may come at the first edge after reset is released
  //
  // limits
  //   the scan sources are stored and read back, but the scan here always starts
  //   at once and steps on drain; other sources are left to the trigger logic
  //   the trigger delay and sample period are handed on, not timed here
  //   the transfer count is handed on with its go pulse; moving data is outside
  //   the operating profile only gates acquire; its other effects are outside
  //   readings per trigger above the buffer depth are not checked here
  //   an unknown command code is ignored without a refusal flag

  typedef struct packed {
    vm_cfg_t     cfg;
    seq_state_t  st;
    logic [3:0]  step;
    logic [2:0]  quantity_select_arg;
    logic        operating_profile;
    logic        intr_en;
    logic [15:0] buffered;
    logic [ST_W-1:0] status;
    logic [ST_W-1:0] mask;
    logic        irq;
    logic [31:0] rdata;
    logic        scan_step;
    logic [15:0] xfer_count;
    logic        xfer_go;
    logic        ready;
    logic        scanning;
  } state_t;

  localparam state_t STATE_RESET = '{
    cfg: CFG_RESET, st: ST_IDLE, step: 4'h0, quantity_select_arg: QUANTITY_SELECT_DCV,
    operating_profile: 1'b0, intr_en: 1'b0, buffered: 16'h0000,
    status: '0, mask: '0, irq: 1'b0, rdata: 32'h0000_0000,
    scan_step: 1'b0, xfer_count: 16'h0000, xfer_go: 1'b0, ready: 1'b0, scanning: 1'b0};

  state_t s_q;
  state_t s_d;

  // next-state logic
  always_comb begin
    logic [ST_W-1:0] ev;
    logic [1:0]      code;
    ev   = '0;
    code = i_wdata[CMD_CODE_LSB +: 2];
    s_d  = s_q;
    s_d.scan_step = 1'b0;
    s_d.xfer_go   = 1'b0;
    s_d.rdata     = 32'h0000_0000;

    // reading buffer occupancy, store and take together leave it unchanged
    if (i_reading_stored && !i_reading_taken) begin
      s_d.buffered = s_q.buffered + 16'h0001;
    end else if (!i_reading_stored && i_reading_taken && s_q.buffered != 16'h0000) begin
      s_d.buffered = s_q.buffered - 16'h0001;
    end
    s_d.ready = (s_d.buffered != 16'h0000);

    // preset sequencer and scan control
    case (s_q.st)
      ST_IDLE: begin
      end
      ST_PRESET: begin
        case (s_q.step)
          4'h0: s_d.cfg.scan_begin_source = SRC_SCAN;
          4'h1: s_d.cfg.scan_step_source  = SRC_SCAN;
          4'h2: s_d.cfg.trig_source       = SRC_HOLD;
          4'h3: s_d.cfg.quantity_select   = s_q.quantity_select_arg;
          4'h4: s_d.cfg.range_sel         = RANGE_AUTO;
          4'h5: s_d.cfg.terminal          = TERM_BUS;
          4'h6: s_d.cfg.samples_per_trigger = NRDG_MIN;
          4'h7: s_d.cfg.destination       = DEST_HOST;
          4'h8: s_d.cfg.result_storage_policy = STORE_ANY;
          4'h9: s_d.cfg.autorange_policy  = AUTORANGE_AFTER;
          4'hA: begin
            s_d.cfg.trig_delay    = TDELAY_PRESET_CYC;
            s_d.cfg.sample_period = SPERIOD_CYC;
          end
          default: s_d.cfg.offset_nulling_mode = NULL_ONCE;
        endcase
        if (s_q.step == PRESET_LAST) begin
          s_d.st   = ST_IDLE;
          s_d.step = 4'h0;
          ev[ST_SETUP_DONE] = 1'b1;
        end else begin
          s_d.step = s_q.step + 4'h1;
        end
      end
      ST_SCAN: begin
        // scan sources are not used here; the scan waits for samples_per_trigger readings
        if (s_q.buffered >= s_q.cfg.samples_per_trigger) begin
          s_d.st = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // step only once the buffer is fully drained
        if (s_q.buffered == 16'h0000 && !i_reading_stored) begin
          s_d.scan_step = 1'b1;
          s_d.st        = ST_SCAN;
          ev[ST_SCAN_STEP] = 1'b1;
        end
      end
      default: s_d.st = ST_IDLE;
    endcase

    // register writes
    if (i_wr) begin
      case (i_addr)
        ADDR_CMD: begin
          if (code == CMD_RESET) begin
            s_d = STATE_RESET;
          end else if (code == CMD_SETUP && s_q.st != ST_PRESET) begin
            s_d.st       = ST_PRESET; // profile untouched
            s_d.step     = 4'h0;
            s_d.quantity_select_arg = i_wdata[CMD_QUANTITY_SELECT_LSB +: 3];
          end else if (code == CMD_ACQUIRE) begin
            if (s_q.intr_en || s_q.operating_profile || s_q.st == ST_PRESET) begin
              ev[ST_REJECT] = 1'b1;
            end else if (s_q.st == ST_IDLE) begin
              s_d.st = ST_SCAN;
            end else begin
              s_d.st = ST_IDLE; // acquire again ends the scan
              ev[ST_SCAN_END] = 1'b1;
            end
          end
        end
        ADDR_QUANTITY_SELECT:    s_d.cfg.quantity_select = i_wdata[2:0];
        ADDR_TRIG:    s_d.cfg.trig_source = i_wdata[1:0];
        ADDR_SCAN: begin
          s_d.cfg.scan_begin_source = i_wdata[1:0];
          s_d.cfg.scan_step_source  = i_wdata[3:2];
        end
        ADDR_RANGE: begin
          s_d.cfg.range_sel         = i_wdata[1:0];
          s_d.cfg.terminal          = i_wdata[2];
          s_d.cfg.autorange_policy  = i_wdata[3];
          s_d.cfg.offset_nulling_mode = i_wdata[5:4];
        end
        ADDR_NRDG: begin
          if (i_wdata[15:0] >= NRDG_MIN) begin
            s_d.cfg.samples_per_trigger = i_wdata[15:0];
          end else begin
            ev[ST_REJECT] = 1'b1;
          end
        end
        ADDR_DEST: begin
          s_d.cfg.destination           = i_wdata[1:0];
          s_d.cfg.result_storage_policy = i_wdata[2];
        end
        ADDR_TDELAY:  s_d.cfg.trig_delay    = i_wdata;
        ADDR_SPERIOD: s_d.cfg.sample_period = i_wdata;
        ADDR_PROFILE: s_d.operating_profile = i_wdata[0];
        ADDR_XFER: begin
          s_d.xfer_go = 1'b1;
          s_d.xfer_count = (i_wdata[15:0] == 16'h0000) ? s_q.cfg.samples_per_trigger
                                                       : i_wdata[15:0];
        end
        ADDR_STATUS:   s_d.status = s_q.status & ~i_wdata[ST_W-1:0];
        ADDR_IRQ_MASK: s_d.mask   = i_wdata[ST_W-1:0];
        ADDR_INTR_EN:  s_d.intr_en = i_wdata[0];
        default: begin
        end
      endcase
    end

    // sticky events, set wins over clear
    s_d.status = s_d.status | ev;
    s_d.irq    = s_d.intr_en && ((s_d.status & s_d.mask) != '0);

    // scan activity kept in its own flop for the output
    s_d.scanning = (s_d.st == ST_SCAN) || (s_d.st == ST_WAIT);

    // register reads, data in the following cycle
    if (i_rd) begin
      case (i_addr)
        ADDR_QUANTITY_SELECT:     s_d.rdata = {29'h0, s_q.cfg.quantity_select};
        ADDR_TRIG:     s_d.rdata = {30'h0, s_q.cfg.trig_source};
        ADDR_SCAN:     s_d.rdata = {28'h0, s_q.cfg.scan_step_source, s_q.cfg.scan_begin_source};
        ADDR_RANGE:    s_d.rdata = {26'h0, s_q.cfg.offset_nulling_mode, s_q.cfg.autorange_policy,
                                    s_q.cfg.terminal, s_q.cfg.range_sel};
        ADDR_NRDG:     s_d.rdata = {16'h0, s_q.cfg.samples_per_trigger};
        ADDR_DEST:     s_d.rdata = {29'h0, s_q.cfg.result_storage_policy, s_q.cfg.destination};
        ADDR_TDELAY:   s_d.rdata = s_q.cfg.trig_delay;
        ADDR_SPERIOD:  s_d.rdata = s_q.cfg.sample_period;
        ADDR_PROFILE:  s_d.rdata = {31'h0, s_q.operating_profile};
        ADDR_XFER:     s_d.rdata = {s_q.buffered, s_q.xfer_count};
        ADDR_STATUS:   s_d.rdata = {24'h0, s_q.st, s_q.status};
        ADDR_IRQ_MASK: s_d.rdata = {28'h0, s_q.mask};
        ADDR_INTR_EN:  s_d.rdata = {31'h0, s_q.intr_en};
        default:       s_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  // state register
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s_q <= STATE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from flops
  assign o_rdata            = s_q.rdata;
  assign o_cfg              = s_q.cfg;
  assign o_scanning         = s_q.scanning;
  assign o_any_result_ready = s_q.ready;
  assign o_scan_step        = s_q.scan_step;
  assign o_xfer_count       = s_q.xfer_count;
  assign o_xfer_go          = s_q.xfer_go;
  assign o_irq              = s_q.irq;

endmodule

// ==== vm_setup_chk.sv ====
// checker: port-level relations of the voltmeter setup block
`timescale 1ns/1ps
module vm_setup_chk
  import vm_setup_pkg::*;
(
  input wire logic        i_sys_clk,
  input wire logic        i_reset_n,
  input wire logic [3:0]  i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic        i_reading_stored,
  input wire logic        i_reading_taken,
  input wire logic [31:0] o_rdata,
  input wire vm_cfg_t     o_cfg,
  input wire logic        o_scanning,
  input wire logic        o_any_result_ready,
  input wire logic        o_scan_step,
  input wire logic [15:0] o_xfer_count,
  input wire logic        o_xfer_go,
  input wire logic        o_irq
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  // command decodes seen on the register port
  wire setup_wr = i_wr && i_addr == ADDR_CMD && i_wdata[1:0] == CMD_SETUP;
  wire reset_wr = i_wr && i_addr == ADDR_CMD && i_wdata[1:0] == CMD_RESET;
  logic en_seen_q;
  // remembers whether software ever enabled interrupts
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) en_seen_q <= 1'b0;
    else if (i_wr && i_addr == ADDR_INTR_EN && i_wdata[0]) en_seen_q <= 1'b1;
  end
  a_reset_defaults: assert property ($rose(i_reset_n) |-> o_cfg == CFG_RESET && !o_irq)
    else $error("config not at reset values");
  a_cmd_reset: assert property (reset_wr |=> ##1 o_cfg == CFG_RESET)
    else $error("reset command did not restore config");
  a_preset_values: assert property (setup_wr |-> ##13 (o_cfg.terminal == TERM_BUS
    && o_cfg.trig_source == SRC_HOLD && o_cfg.samples_per_trigger == 16'h0001
    && o_cfg.trig_delay == TDELAY_PRESET_CYC && o_cfg.sample_period == SPERIOD_CYC
    && o_cfg.destination == DEST_HOST && o_cfg.quantity_select == $past(i_wdata[4:2], 13)))
    else $error("preset values wrong");
  a_preset_order: assert property (setup_wr |=> $stable(o_cfg.trig_delay) [*8])
    else $error("delay loaded out of order");
  a_xfer_count: assert property (i_wr && i_addr == ADDR_XFER |=> o_xfer_go && o_xfer_count ==
    ($past(i_wdata[15:0]) == 16'h0000 ? $past(o_cfg.samples_per_trigger) : $past(i_wdata[15:0])))
    else $error("transfer count wrong");
  a_irq_off: assert property (!en_seen_q |-> !o_irq)
    else $error("interrupt before enable");
  a_nrdg_read: assert property (i_rd && i_addr == ADDR_NRDG |=> o_rdata == {16'h0000, $past(o_cfg.samples_per_trigger)})
    else $error("readings count readback wrong");
  a_step_drained: assert property (o_scan_step |-> !o_any_result_ready && o_scanning)
    else $error("scan stepped with readings held");
  a_ready_store: assert property (i_reading_stored && !i_reading_taken |-> ##[1:2] o_any_result_ready)
    else $error("data ready flag missing");
  c_step: cover property (o_scan_step);
  c_irq: cover property (o_irq);
  c_setup: cover property (setup_wr ##13 1'b1);
endmodule
bind voltmeter_setup_preset_state vm_setup_chk chk_u (.i_sys_clk, .i_reset_n, .i_addr, .i_wdata, .i_wr, .i_rd,
  .i_reading_stored, .i_reading_taken, .o_rdata, .o_cfg, .o_scanning, .o_any_result_ready, .o_scan_step,
  .o_xfer_count, .o_xfer_go, .o_irq);

// ==== vm_buffer_model.sv ====
// partner model: reading buffer that stores and hands out readings
`timescale 1ns/1ps
module vm_buffer_model (
  input  wire logic i_sys_clk,
  input  wire logic i_reset_n,
  input  wire logic i_store,
  input  wire logic i_take,
  output logic      o_reading_stored,
  output logic      o_reading_taken
);
  logic [15:0] held_q;
  // a reading leaves only when one is held
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      held_q <= 16'h0000;
      o_reading_stored <= 1'b0;
      o_reading_taken <= 1'b0;
    end else begin
      o_reading_stored <= i_store;
      o_reading_taken <= i_take && held_q != 16'h0000;
      held_q <= held_q + 16'(i_store) - 16'(i_take && held_q != 16'h0000);
    end
  end
endmodule

// ==== voltmeter_setup_preset_state_bench.sv ====
// testbench: scenarios for the voltmeter setup block
`timescale 1ns/1ps
module voltmeter_setup_preset_state_bench;
  import vm_setup_pkg::*;
  logic        i_sys_clk, stored, taken, o_scanning, o_any_result_ready, o_scan_step, o_xfer_go, o_irq;
  logic        i_reset_n = 0, i_wr = 0, i_rd = 0, do_store = 0, do_take = 0;
  logic [3:0]  i_addr = 4'h0;
  logic [31:0] i_wdata = 32'h0000_0000, o_rdata, rv;
  logic [15:0] o_xfer_count;
  vm_cfg_t     o_cfg, e;
  int          err_total = 0, total_checks = 0;
  voltmeter_setup_preset_state dut_u (.i_sys_clk, .i_reset_n, .i_addr, .i_wdata, .i_wr, .i_rd,
    .i_reading_stored(stored), .i_reading_taken(taken), .o_rdata, .o_cfg, .o_scanning,
    .o_any_result_ready, .o_scan_step, .o_xfer_count, .o_xfer_go, .o_irq);
  vm_buffer_model buf_u (.i_sys_clk, .i_reset_n, .i_store(do_store), .i_take(do_take),
    .o_reading_stored(stored), .o_reading_taken(taken));
  // 25 MHz clock
  initial begin
    i_sys_clk = 0;
    forever #20 i_sys_clk = ~i_sys_clk;
  end
  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge i_sys_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 rv = o_rdata;
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic t_power_on();
    chk(128'(o_cfg), 128'(CFG_RESET));
    chk(128'(o_irq), 128'(1'b0));
    rd(ADDR_PROFILE);
    chk(128'(rv[0]), 128'(1'b0));
    rd(4'hE);
    chk(128'(rv), 128'(0));
    $display("power-on test done");
  endtask
  task automatic t_setup();
    wr(ADDR_NRDG, 32'h0000_0009);
    wr(ADDR_PROFILE, 32'h0000_0001);
    wr(ADDR_CMD, 32'h0000_0009);
    tick(6);
    chk(128'(o_cfg.terminal), 128'(TERM_BUS));
    chk(128'(o_cfg.trig_delay), 128'(0));
    tick(6);
    e = CFG_RESET;
    e.quantity_select = 3'h2;
    e.terminal = TERM_BUS;
    e.trig_delay = TDELAY_PRESET_CYC;
    chk(128'(o_cfg), 128'(e));
    rd(ADDR_PROFILE);
    chk(128'(rv[0]), 128'(1'b1));
    wr(ADDR_PROFILE, 32'h0000_0000);
    $display("setup test done");
  endtask
  task automatic t_lowlevel();
    wr(ADDR_NRDG, 32'h0000_0002);
    wr(ADDR_NRDG, 32'h0000_0000);
    rd(ADDR_NRDG);
    chk(128'(rv), 128'(2));
    rd(ADDR_STATUS);
    chk(128'(rv[ST_REJECT]), 128'(1'b1));
    wr(ADDR_XFER, 32'h0000_0000);
    #1 chk(128'({o_xfer_go, o_xfer_count}), 128'({1'b1, 16'h0002}));
    wr(ADDR_XFER, 32'h0000_0005);
    #1 chk(128'(o_xfer_count), 128'(5));
    $display("low-level test done");
  endtask
  task automatic t_acquire();
    int n;
    wr(ADDR_CMD, 32'(CMD_ACQUIRE)); // interrupts are off here
    tick(1);
    chk(128'(o_scanning), 128'(1'b1));
    @(posedge i_sys_clk) do_store <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
    do_store <= 1'b0;
    tick(3);
    chk(128'(o_any_result_ready), 128'(1'b1));
    @(posedge i_sys_clk) do_take <= 1'b1;
    @(posedge i_sys_clk) do_take <= 1'b0;
    for (n = 0; n < 5; n++) begin
      tick(1);
      chk(128'(o_scan_step), 128'(1'b0));
    end
    @(posedge i_sys_clk) do_take <= 1'b1;
    @(posedge i_sys_clk) do_take <= 1'b0;
    for (n = 0; n < 10 && o_scan_step !== 1'b1; n++) tick(1);
    chk(128'(o_scan_step), 128'(1'b1));
    if (o_scan_step !== 1'b1) print_verdict();
    wr(ADDR_CMD, 32'(CMD_ACQUIRE));
    tick(1);
    chk(128'(o_scanning), 128'(1'b0));
    $display("acquire test done");
  endtask
  task automatic t_irq();
    wr(ADDR_STATUS, 32'h0000_000F);
    wr(ADDR_IRQ_MASK, 32'h0000_000F);
    wr(ADDR_CMD, 32'(CMD_SETUP));
    tick(14);
    chk(128'(o_irq), 128'(1'b0));
    wr(ADDR_INTR_EN, 32'h0000_0001);
    tick(2);
    chk(128'(o_irq), 128'(1'b1));
    wr(ADDR_IRQ_MASK, 32'h0000_0000);
    tick(2);
    chk(128'(o_irq), 128'(1'b0));
    wr(ADDR_CMD, 32'(CMD_ACQUIRE));
    tick(2);
    chk(128'(o_scanning), 128'(1'b0));
    rd(ADDR_STATUS);
    chk(128'(rv[ST_REJECT]), 128'(1'b1));
    wr(ADDR_STATUS, 32'h0000_000F);
    wr(ADDR_INTR_EN, 32'h0000_0000);
    $display("interrupt test done");
  endtask
  task automatic t_reset_cmd();
    wr(ADDR_NRDG, 32'h0000_0004);
    wr(ADDR_CMD, 32'(CMD_RESET));
    tick(1);
    chk(128'(o_cfg), 128'(CFG_RESET));
    $display("reset command test done");
  endtask
  // main sequence
  initial begin
    repeat (3) @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    tick(1);
    t_power_on();
    t_setup();
    t_lowlevel();
    t_acquire();
    t_irq();
    t_reset_cmd();
    print_verdict();
  end
endmodule
